// ### design/tpq_params.svh
`ifndef TPQ_PARAMS_SVH
`define TPQ_PARAMS_SVH
// Packet numbers, page sizing and queue depths.
`define TPQ_PNUM_W      6
`define TPQ_NPKT        64
`define TPQ_PAGE_BYTES  256
`define TPQ_TOTAL_PAGES 32
`define TPQ_PAGE_W      6
`define TPQ_CNT_W       11
`define TPQ_QDEPTH      64
`define TPQ_QPTR_W      6
// Buffer word address: packet number then word offset.
`define TPQ_WOFS_W      9
`define TPQ_MEM_AW      15
// Command codes on the host command port.
`define TPQ_CMD_NONE    3'h0
`define TPQ_CMD_ALLOC   3'h1
`define TPQ_CMD_ENQ     3'h2
`define TPQ_CMD_REL     3'h3
`define TPQ_CMD_ACK     3'h4
// Reset values.
`define TPQ_TXEN_RST    1'h0
`define TPQ_AUTO_RST    1'h0
`endif

// ### design/tpq_pkg.sv
`include "tpq_params.svh"
package tpq_pkg;
  // Host command with its argument.
  typedef struct packed {
    logic [2:0]                 code;
    logic [`TPQ_CNT_W-1:0]      bytes;
  } tpq_cmd_t;
  // Report from the MAC at the end of a frame.
  typedef struct packed {
    logic                       ok;
    logic [15:0]                status;
  } tpq_done_t;
  typedef enum logic [2:0] {
    TPQ_IDLE = 3'b001,
    TPQ_SEND = 3'b010,
    TPQ_STAT = 3'b100
  } tpq_state_t;
endpackage

// ### design/tpq_tx_queue.sv
`timescale 1ns/1ps
`include "tpq_params.svh"
// Behaviour
// R1 - With auto free off, buffers stay allocated and finished numbers enter completion FIFO.
// R2 - Allocate command tries to reserve requested byte count in buffer memory.
// R3 - Successful allocation sets the allocation done flag.
// R4 - Allocated packet number appears in the allocation result output.
// R5 - Host copies number, sets pointer, then streams frame data.
// R6 - Enqueue pushes current packet number into the transmit FIFO.
// R7 - Packet goes to MAC only with transmit enable and, half duplex, deferral permit.
// R8 - On completion the status word overwrites the first buffer word.
// R9 - On completion the number moves from transmit FIFO to completion FIFO.
// R10 - Transmit interrupt is raised while completion FIFO is not empty.
// R11 - Failure sets event flag, clears transmit enable, and stops sending.
// R12 - After failure the failed packet number shows at the FIFO ports output; with auto free on the code frees it without queuing it.
// R13 - FIFO ports output shows the completion FIFO head number.
// R14 - With packet number written, its status word is readable through buffer path.
// R15 - Release returns all memory of the packet number register's packet.
// R16 - Acknowledge pops the head of the completion FIFO.
// R17 - After failure host frees, or re-enables transmit and re-enqueues.
// R18 - With auto free on, pages are released at completion by the device.
// R19 - Host enqueues only after the whole frame is written.
module tpq_tx_queue (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Host commands and configuration.
  input  wire tpq_pkg::tpq_cmd_t         cmd,
  input  wire logic [`TPQ_PNUM_W-1:0]    pnum_wr,
  input  wire logic                      pnum_we,
  input  wire logic                      txen_set,
  input  wire logic                      auto_free,
  input  wire logic                      half_duplex,
  // Host buffer access.
  input  wire logic [`TPQ_WOFS_W-1:0]    ptr,
  input  wire logic                      data_we,
  input  wire logic [15:0]               data_wr,
  output logic      [15:0]               data_rd,
  // Host status.
  output logic                           alloc_done_flag,
  output logic                           alloc_fail,
  output logic [`TPQ_PNUM_W-1:0]         alloc_result,
  output logic                           tx_enable_bit,
  output logic                           tx_event_flag,
  output logic                           tx_int,
  output logic [`TPQ_PNUM_W-1:0]         fifo_ports,
  output logic                           fifo_ports_empty,
  // MAC side.
  input  wire logic                      defer_ok,
  output logic                           mac_start,
  output logic [`TPQ_PNUM_W-1:0]         mac_pnum,
  input  wire logic                      mac_done,
  input  wire tpq_pkg::tpq_done_t        mac_result
);

  // Free/used state per packet number and page usage.
  logic [`TPQ_NPKT-1:0]                  used_q;
  logic [`TPQ_PAGE_W-1:0]                pages_q [`TPQ_NPKT];
  logic [`TPQ_PAGE_W:0]                  free_pages_q;
  logic [`TPQ_PNUM_W-1:0]                pnum_q;
  logic [15:0]                           mem [2**`TPQ_MEM_AW];
  // Transmit and completion FIFOs.
  logic [`TPQ_PNUM_W-1:0]                txq [`TPQ_QDEPTH];
  logic [`TPQ_PNUM_W-1:0]                cq  [`TPQ_QDEPTH];
  logic [`TPQ_QPTR_W:0]                  txq_wp_q, txq_rp_q, cq_wp_q, cq_rp_q;
  tpq_pkg::tpq_state_t                   st_q;
  logic [`TPQ_PNUM_W-1:0]                cur_q;
  logic [`TPQ_PNUM_W-1:0]                pnum_eff;
  logic                                  txq_empty, cq_empty, cq_full;
  logic                                  do_start, do_done;
  logic                                  is_free;
  logic [`TPQ_PNUM_W-1:0]                free_idx;
  logic [`TPQ_PAGE_W:0]                  need;
  logic                                  cq_push, cq_pop;
  logic                                  alloc_go, rel_go, auto_go;
  logic [`TPQ_PAGE_W:0]                  take_pages, rel_pages, auto_pages;

  // Pages needed for a byte count, rounded up.
  function automatic logic [`TPQ_PAGE_W:0] pages_for(input logic [`TPQ_CNT_W-1:0] n);
    logic [`TPQ_CNT_W:0] s;
    s = {1'b0, n} + (`TPQ_CNT_W+1)'(`TPQ_PAGE_BYTES - 1);
    pages_for = (`TPQ_PAGE_W+1)'(s >> 8);
  endfunction

  // Full when the pointers differ only in their wrap bit; used by both queues.
  function automatic logic q_full(input logic [`TPQ_QPTR_W:0] wp,
                                  input logic [`TPQ_QPTR_W:0] rp);
    q_full = (wp[`TPQ_QPTR_W] != rp[`TPQ_QPTR_W]) &&
             (wp[`TPQ_QPTR_W-1:0] == rp[`TPQ_QPTR_W-1:0]);
  endfunction

  // Lowest free packet number by a priority scan.
  always_comb begin
    is_free  = 1'b0;
    free_idx = '0;
    for (int i = `TPQ_NPKT-1; i >= 0; i--) begin
      if (!used_q[i]) begin
        is_free  = 1'b1;
        free_idx = `TPQ_PNUM_W'(i);
      end
    end
  end

  // Queue flags, and a pnum write in the same cycle is seen by the command.
  assign pnum_eff  = pnum_we ? pnum_wr : pnum_q;
  assign txq_empty = (txq_wp_q == txq_rp_q);
  assign cq_empty  = (cq_wp_q == cq_rp_q);
  assign cq_full   = q_full(cq_wp_q, cq_rp_q);
  assign need      = pages_for(cmd.bytes);
  assign do_start  = (st_q == tpq_pkg::TPQ_IDLE) && !txq_empty && tx_enable_bit &&
                     (!half_duplex || defer_ok);                              // R7
  assign do_done   = (st_q == tpq_pkg::TPQ_SEND) && mac_done;
  // A completion that auto frees skips the completion FIFO.
  assign cq_push   = do_done && !auto_free && !cq_full;                       // R1
  assign cq_pop    = (cmd.code == `TPQ_CMD_ACK) && !cq_empty;                 // R16

  // Frees and the allocation are summed rather than prioritised, so a command that lands
  // in the cycle of an automatic free cannot leak its pages.
  assign alloc_go   = (cmd.code == `TPQ_CMD_ALLOC) && is_free &&
                      need <= free_pages_q && need != '0;                     // R2
  assign rel_go     = (cmd.code == `TPQ_CMD_REL) && used_q[pnum_eff];         // R15
  assign auto_go    = do_done && auto_free && used_q[cur_q] &&
                      !(rel_go && pnum_eff == cur_q);                         // R18
  assign take_pages = alloc_go ? need : '0;
  assign rel_pages  = rel_go ? {1'b0, pages_q[pnum_eff]} : '0;
  assign auto_pages = auto_go ? {1'b0, pages_q[cur_q]} : '0;

  // Packet number register.
  always_ff @(posedge clk) begin
    if (!nrst) pnum_q <= '0;
    else if (pnum_we) pnum_q <= pnum_wr;
  end

  // Allocation, release and automatic free of packet buffers.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      used_q          <= '0;
      free_pages_q    <= (`TPQ_PAGE_W+1)'(`TPQ_TOTAL_PAGES);
      alloc_done_flag <= 1'b0;
      alloc_fail      <= 1'b0;
      alloc_result    <= '0;
    end else begin
      free_pages_q <= free_pages_q + rel_pages + auto_pages - take_pages;
      if (cmd.code == `TPQ_CMD_ALLOC) begin                                   // R2
        if (alloc_go) begin
          used_q[free_idx]  <= 1'b1;
          pages_q[free_idx] <= `TPQ_PAGE_W'(need);
          alloc_result      <= free_idx;                                      // R4
          alloc_done_flag   <= 1'b1;                                          // R3
          alloc_fail        <= 1'b0;
        end else begin
          alloc_done_flag   <= 1'b0;
          alloc_fail        <= 1'b1;
        end
      end
      if (rel_go) used_q[pnum_eff] <= 1'b0;                                   // R15
      if (auto_go) used_q[cur_q] <= 1'b0;                                     // R18
    end
  end

  // Buffer memory: host writes, status overwrite at completion, host reads.
  always_ff @(posedge clk) begin
    if (do_done) begin
      mem[{cur_q, `TPQ_WOFS_W'(0)}] <= mac_result.status;                     // R8
    end else if (data_we) begin
      mem[{pnum_q, ptr}] <= data_wr;                                          // R5
    end
  end

  // Read through the packet number register, so status is visible after completion.
  always_ff @(posedge clk) begin
    if (!nrst) data_rd <= '0;
    else data_rd <= mem[{pnum_q, ptr}];                                       // R14
  end

  // Transmit FIFO: enqueue at the tail, removal when the MAC finishes.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txq_wp_q <= '0;
      txq_rp_q <= '0;
    end else begin
      if (cmd.code == `TPQ_CMD_ENQ && !q_full(txq_wp_q, txq_rp_q)) begin
        txq[txq_wp_q[`TPQ_QPTR_W-1:0]] <= pnum_eff;                           // R6
        txq_wp_q <= txq_wp_q + 1'b1;
      end
      if (do_done) txq_rp_q <= txq_rp_q + 1'b1;                               // R9
    end
  end

  // Completion FIFO with the host acknowledge pop.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cq_wp_q <= '0;
      cq_rp_q <= '0;
    end else begin
      if (cq_push) begin
        cq[cq_wp_q[`TPQ_QPTR_W-1:0]] <= cur_q;                                // R9
        cq_wp_q <= cq_wp_q + 1'b1;
      end
      if (cq_pop) cq_rp_q <= cq_rp_q + 1'b1;                                  // R16
    end
  end

  // Completion head presented to the host; empty shows as a flag.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fifo_ports       <= '0;
      fifo_ports_empty <= 1'b1;
      tx_int           <= 1'b0;
    end else begin
      fifo_ports_empty <= ((cq_wp_q + (`TPQ_QPTR_W+1)'(cq_push)) ==
                           (cq_rp_q + (`TPQ_QPTR_W+1)'(cq_pop)));
      tx_int           <= ((cq_wp_q + (`TPQ_QPTR_W+1)'(cq_push)) !=
                           (cq_rp_q + (`TPQ_QPTR_W+1)'(cq_pop)));             // R10
      // A push into a queue that a same-cycle pop empties is the new head at once.
      if (cq_push && (cq_wp_q == cq_rp_q + (`TPQ_QPTR_W+1)'(cq_pop)))
        fifo_ports <= cur_q;                                                  // R12
      else if (!cq_empty) fifo_ports <= cq[cq_rp_q[`TPQ_QPTR_W-1:0] +
                                          `TPQ_QPTR_W'(cq_pop)];              // R13
    end
  end

  // Sequencer toward the MAC.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q      <= tpq_pkg::TPQ_IDLE;
      cur_q     <= '0;
      mac_start <= 1'b0;
      mac_pnum  <= '0;
    end else begin
      mac_start <= 1'b0;
      unique case (st_q)
        tpq_pkg::TPQ_IDLE: begin
          if (do_start) begin                                                 // R7
            cur_q     <= txq[txq_rp_q[`TPQ_QPTR_W-1:0]];
            mac_pnum  <= txq[txq_rp_q[`TPQ_QPTR_W-1:0]];
            mac_start <= 1'b1;
            st_q      <= tpq_pkg::TPQ_SEND;
          end
        end
        tpq_pkg::TPQ_SEND: begin
          if (mac_done) st_q <= tpq_pkg::TPQ_STAT;
        end
        tpq_pkg::TPQ_STAT: begin
          st_q <= tpq_pkg::TPQ_IDLE;
        end
        default: st_q <= tpq_pkg::TPQ_IDLE;
      endcase
    end
  end

  // Transmit enable and failure event; failure beats a same-cycle set.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_enable_bit <= `TPQ_TXEN_RST;
      tx_event_flag <= 1'b0;
    end else begin
      if (do_done && !mac_result.ok) begin                                    // R11
        tx_enable_bit <= 1'b0;
        tx_event_flag <= 1'b1;
      end else if (txen_set) begin
        tx_enable_bit <= 1'b1;
        tx_event_flag <= 1'b0;
      end
    end
  end

  // Checks.
  a_fail_stops: assert property (@(posedge clk) disable iff (!nrst)          // R11
    (do_done && !mac_result.ok) |=> !tx_enable_bit && tx_event_flag)
    else $error("failure did not stop transmit");
  a_start_gated: assert property (@(posedge clk) disable iff (!nrst)         // R7
    mac_start |-> $past(tx_enable_bit) && ($past(defer_ok) || !$past(half_duplex)))
    else $error("start without enable or deferral");
  a_int_level: assert property (@(posedge clk) disable iff (!nrst)           // R10
    !cq_empty |=> ##0 (tx_int || cq_pop || $past(cq_pop)))
    else $error("interrupt missing while completion queue holds entries");
  a_int_clear: assert property (@(posedge clk) disable iff (!nrst)           // R10
    tx_int |-> !fifo_ports_empty)
    else $error("interrupt with empty completion queue");
  a_alloc_flag: assert property (@(posedge clk) disable iff (!nrst)          // R3
    alloc_done_flag && $changed(alloc_result) |-> used_q[alloc_result])
    else $error("allocation result not marked used");
  a_done_moves: assert property (@(posedge clk) disable iff (!nrst)          // R9
    (do_done && !auto_free && cq_empty && !cq_pop) |=> !fifo_ports_empty
      && fifo_ports == $past(cur_q))
    else $error("completed number not in completion queue");
  a_send_one: assert property (@(posedge clk) disable iff (!nrst)            // R7
    mac_start |=> !mac_start)
    else $error("double start");
  a_ack_pop: assert property (@(posedge clk) disable iff (!nrst)             // R16
    cq_pop |=> cq_rp_q == $past(cq_rp_q) + 1'b1)
    else $error("acknowledge did not pop");
  a_alloc_fail: assert property (@(posedge clk) disable iff (!nrst)          // R2
    (cmd.code == `TPQ_CMD_ALLOC && need > free_pages_q) |=>
      alloc_fail && !alloc_done_flag)
    else $error("allocation beyond the free pages accepted");
  a_rel_frees: assert property (@(posedge clk) disable iff (!nrst)           // R15
    rel_go |=> !used_q[$past(pnum_eff)])
    else $error("release left the number in use");
  a_keep_alloc: assert property (@(posedge clk) disable iff (!nrst)          // R1
    (do_done && !auto_free && !rel_go) |=> used_q[$past(cur_q)])
    else $error("buffer freed without a release");
  a_txq_pop: assert property (@(posedge clk) disable iff (!nrst)             // R9
    do_done |=> txq_rp_q == $past(txq_rp_q) + 1'b1)
    else $error("completion did not leave the transmit queue");
  // Covers for the main scenarios.
  c_send: cover property (@(posedge clk) disable iff (!nrst) mac_start);
  c_fail: cover property (@(posedge clk) disable iff (!nrst) do_done && !mac_result.ok);
  c_ack:  cover property (@(posedge clk) disable iff (!nrst) cq_pop);
  c_alloc_fail: cover property (@(posedge clk) disable iff (!nrst) alloc_fail);
  c_auto_free:  cover property (@(posedge clk) disable iff (!nrst) auto_go);
endmodule

// ### verif/tpq_mac_model.sv
`timescale 1ns/1ps
`include "tpq_params.svh"
// Far-end MAC: one frame per start pulse, frame length cycling from 1 to 4 cycles.
module tpq_mac_model (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Queue side.
  input  wire logic                    mac_start,
  input  wire logic [`TPQ_PNUM_W-1:0]  mac_pnum,
  output logic                         mac_done,
  output tpq_pkg::tpq_done_t           mac_result,
  // Bench control: report the coming frame as failed.
  input  wire logic                    fail_req
);
  logic [1:0]             len_q;
  logic [2:0]             wait_q;
  logic [`TPQ_PNUM_W-1:0] pnum_q;
  // Result lines toggle outside the done cycle, so a stale report never passes for a new one.
  always_ff @(posedge clk) begin
    mac_done   <= 1'b0;
    mac_result <= ~mac_result;
    if (!nrst) begin
      wait_q     <= '0;
      len_q      <= '0;
      mac_result <= '0;
    end else if (mac_start) begin
      pnum_q <= mac_pnum;
      wait_q <= {1'b0, len_q} + 3'h1;
      len_q  <= len_q + 2'h1;
    end else if (wait_q == 3'h1) begin
      wait_q     <= '0;
      mac_done   <= 1'b1;
      mac_result <= '{ok: !fail_req, status: {8'hA5, 2'h0, pnum_q}};
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
  end
endmodule

// ### verif/tpq_tx_queue_tb_top.sv
`timescale 1ns/1ps
`include "tpq_params.svh"
module tpq_tx_queue_tb_top;
  logic clk = 0, nrst = 0, pnum_we = 0, txen_set = 0, auto_free = 0, half_duplex = 0;
  logic data_we = 0, defer_ok = 0, fail_req = 0, mac_done, mac_start;
  logic alloc_done_flag, alloc_fail, tx_enable_bit, tx_event_flag, tx_int, fifo_ports_empty;
  tpq_pkg::tpq_cmd_t        cmd = '0;
  tpq_pkg::tpq_done_t       mac_result;
  logic [5:0]               pnum_wr = '0, alloc_result, fifo_ports, mac_pnum, a, b, c, d;
  logic [8:0]               ptr = '0;
  logic [15:0]              data_wr = '0, data_rd, w;
  logic [5:0]               exp_q[$];
  logic [5:0]               pool[4];
  int                       err_total = 0, compares = 0;
  integer                   seed = 32'hB0EC82F8;
  tpq_tx_queue u_dut (.clk(clk), .nrst(nrst), .cmd(cmd), .pnum_wr(pnum_wr), .pnum_we(pnum_we),
    .txen_set(txen_set), .auto_free(auto_free), .half_duplex(half_duplex), .ptr(ptr),
    .data_we(data_we), .data_wr(data_wr), .data_rd(data_rd), .alloc_done_flag(alloc_done_flag),
    .alloc_fail(alloc_fail), .alloc_result(alloc_result), .tx_enable_bit(tx_enable_bit),
    .tx_event_flag(tx_event_flag), .tx_int(tx_int), .fifo_ports(fifo_ports),
    .fifo_ports_empty(fifo_ports_empty), .defer_ok(defer_ok), .mac_start(mac_start),
    .mac_pnum(mac_pnum), .mac_done(mac_done), .mac_result(mac_result));
  tpq_mac_model u_mac (.clk(clk), .nrst(nrst), .mac_start(mac_start), .mac_pnum(mac_pnum),
    .mac_done(mac_done), .mac_result(mac_result), .fail_req(fail_req));
  // Free-running 40 ns clock.
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic bad(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) bad(m);
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_cmd(input logic [2:0] code, input logic [10:0] bytes = '0);
    // The idle cycle after each command keeps two calls from touching cmd in one step.
    cmd = '{code: code, bytes: bytes};
    tick();
    cmd = '0;
    tick();
  endtask
  task automatic set_pnum(input logic [5:0] n);
    pnum_wr = n;
    pnum_we = 1;
    tick();
    pnum_we = 0;
  endtask
  task automatic pulse_txen;
    txen_set = 1;
    tick();
    txen_set = 0;
  endtask
  task automatic alloc(input logic [10:0] bytes, output logic [5:0] n);
    do_cmd(`TPQ_CMD_ALLOC, bytes);
    chk({alloc_done_flag, alloc_fail}, 16'h2, "alloc flags");
    n = alloc_result;
  endtask
  task automatic rd_chk(input logic [8:0] ofs, input logic [15:0] exp);
    ptr = ofs;
    tick(2);
    chk(data_rd, exp, "buffer read");
  endtask
  task automatic wait_int(input logic [5:0] n);
    for (int i = 0; i < 20 && tx_int !== 1'b1; i++) tick();
    chk({tx_int, fifo_ports_empty, 8'h0, fifo_ports}, {2'h2, 8'h0, n}, "completion head");
  endtask
  // A start pulse is matched against the oldest packet that the bench has allowed to go.
  always @(negedge clk) begin
    if (nrst && mac_start === 1'b1) begin
      if (exp_q.size() == 0) bad("start while not allowed");
      else chk(16'(mac_pnum), 16'(exp_q.pop_front()), "started number");
    end
  end
  // Watchdog sized well above the roughly 135 cycles of the sequence.
  initial begin
    #(40 * 3000);
    bad("watchdog expired");
    finish_test();
  end
  // Main sequence.
  initial begin
    tick(8);
    nrst = 1;
    chk({alloc_done_flag, tx_enable_bit, tx_int, mac_start, fifo_ports_empty}, 16'h1, "reset");
    alloc(11'($random(seed) & 32'h3FF) | 11'h1, a);
    set_pnum(a);
    w = 16'($random(seed));
    data_we = 1;
    data_wr = w;
    ptr = 9'h3;
    tick();
    data_we = 0;
    rd_chk(9'h3, w);
    do_cmd(`TPQ_CMD_ENQ);
    tick(6);
    exp_q.push_back(a);
    pulse_txen();
    wait_int(a);
    set_pnum(a);
    rd_chk(9'h0, {10'h294, a});
    do_cmd(`TPQ_CMD_ACK);
    tick();
    chk({tx_int, fifo_ports_empty}, 16'h1, "ack pop");
    do_cmd(`TPQ_CMD_REL);
    $display("test basic done");
    half_duplex = 1;
    alloc(11'h80, b);
    set_pnum(b);
    do_cmd(`TPQ_CMD_ENQ);
    tick(6);
    exp_q.push_back(b);
    defer_ok = 1;
    wait_int(b);
    do_cmd(`TPQ_CMD_ACK);
    do_cmd(`TPQ_CMD_REL);
    half_duplex = 0;
    $display("test deferral done");
    alloc(11'h100, c);
    alloc(11'h100, d);
    chk(16'(c != d), 16'h1, "distinct numbers");
    fail_req = 1;
    exp_q.push_back(c);
    set_pnum(c);
    do_cmd(`TPQ_CMD_ENQ);
    set_pnum(d);
    do_cmd(`TPQ_CMD_ENQ);
    wait_int(c);
    tick(6);
    chk({tx_event_flag, tx_enable_bit}, 16'h2, "failure stop");
    fail_req = 0;
    do_cmd(`TPQ_CMD_ACK);
    exp_q.push_back(d);
    exp_q.push_back(c);
    set_pnum(c);
    pulse_txen();
    do_cmd(`TPQ_CMD_ENQ);
    chk(16'(tx_event_flag), 16'h0, "event cleared");
    tick();
    wait_int(d);
    tick(10);
    do_cmd(`TPQ_CMD_ACK);
    wait_int(c);
    do_cmd(`TPQ_CMD_ACK);
    do_cmd(`TPQ_CMD_REL);
    set_pnum(d);
    do_cmd(`TPQ_CMD_REL);
    $display("test failure done");
    auto_free = 1;
    alloc(11'h10, a);
    set_pnum(a);
    exp_q.push_back(a);
    do_cmd(`TPQ_CMD_ENQ);
    tick(12);
    chk({tx_int, fifo_ports_empty}, 16'h1, "auto free skips completion");
    auto_free = 0;
    // Four maximal packets fill the whole pool only if every earlier page came back.
    for (int i = 0; i < 4; i++) alloc(11'h7FF, pool[i]);
    do_cmd(`TPQ_CMD_ALLOC, 11'h7FF);
    chk({alloc_done_flag, alloc_fail}, 16'h1, "pool exhausted");
    set_pnum(pool[2]);
    do_cmd(`TPQ_CMD_REL);
    alloc(11'h7FF, pool[2]);
    $display("test pool done");
    finish_test();
  end
endmodule
